// >>> logic/ccn_pkg.sv
// ccn_pkg.sv - constants and types for the cycle and event counter unit
`default_nettype none

package ccn_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int STAMP_W = 64;
  localparam int CTR_W   = 40;
  localparam int SETUP_W = 32;
  localparam int EVN_W   = 4;   // bits of the event number reported per cycle per source
  localparam int NCTR    = 2;
  localparam int HOLD_W  = 4;

  // ************************************************************
  // setup register field positions
  // ************************************************************
  localparam int EVSEL_LSB = 0;
  localparam int EVSEL_MSB = 7;
  localparam int UMASK_LSB = 8;
  localparam int UMASK_MSB = 15;
  localparam int USR_BIT   = 16;
  localparam int OS_BIT    = 17;
  localparam int EDGE_BIT  = 18;
  localparam int PC_BIT    = 19;
  localparam int INT_BIT   = 20;
  localparam int EN_BIT    = 22;
  localparam int INV_BIT   = 23;
  localparam int CMASK_LSB = 24;
  localparam int CMASK_MSB = 31;
  localparam int WR_LOW_W  = 32;  // bits of a counter write kept as given
  localparam int SIGN_BIT  = 31;

  // ************************************************************
  // control register four and feature word
  // ************************************************************
  localparam int TSD_BIT      = 2;  // restrict_stamp_read
  localparam int PCE_BIT      = 8;  // restrict_counter_read
  localparam int FEAT_TSC_BIT = 4;
  localparam logic [31:0] FEAT_WORD = 32'h0000_0010;
  localparam logic [1:0]  CPL_RING0 = 2'h0;

  // ************************************************************
  // timing: monitor pin pulse lasts two bus clocks
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int BUS_PERIOD_NS = 16;
  localparam int PIN_BUS_CLKS  = 2;
  localparam int PIN_HOLD_CYC  =
    (PIN_BUS_CLKS * BUS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [HOLD_W-1:0] PIN_HOLD_LOAD = HOLD_W'(PIN_HOLD_CYC - 1);

  // ************************************************************
  // request and answer carriers
  // ************************************************************
  typedef enum logic [1:0] {
    OP_MODEL_RD = 2'h0,
    OP_MODEL_WR = 2'h1,
    OP_STAMP_RD = 2'h2,
    OP_COUNT_RD = 2'h3
  } ccn_op_t;

  typedef enum logic [2:0] {
    SEL_STAMP  = 3'h0,
    SEL_SETUP0 = 3'h1,
    SEL_SETUP1 = 3'h2,
    SEL_COUNT0 = 3'h3,
    SEL_COUNT1 = 3'h4
  } ccn_sel_t;

  typedef struct packed {
    logic                 valid;
    ccn_op_t              op;
    ccn_sel_t             sel;
    logic [STAMP_W-1:0]   wdata;
  } ccn_req_t;

  typedef struct packed {
    logic                 valid;
    logic                 fault;
    logic [STAMP_W-1:0]   data;
  } ccn_rsp_t;

  typedef enum logic [1:0] {
    PIN_IDLE = 2'b01,
    PIN_HIGH = 2'b10
  } ccn_pin_t;

  typedef struct packed {
    logic [STAMP_W-1:0]             stamp;
    logic [NCTR-1:0][SETUP_W-1:0]   setup;
    logic [NCTR-1:0][CTR_W-1:0]     count;
    logic [NCTR-1:0]                prev_cond;
    ccn_pin_t [NCTR-1:0]            pin_st;
    logic [NCTR-1:0][HOLD_W-1:0]    hold;
    logic [NCTR-1:0]                pins;
    logic                           irq;
    logic [31:0]                    feat;
    ccn_rsp_t                       rsp;
  } ccn_state_t;

endpackage : ccn_pkg

`default_nettype wire

// >>> logic/ccn_top.sv
// ccn_top.sv - cycle stamp counter and two event/duration counters
`timescale 1ns/1ps
`default_nettype none

module ccn_top (
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  input  wire logic [1:0]                            cur_priv,
  input  wire logic                                  v86_mode,
  input  wire logic [31:0]                           control_reg_four,
  input  wire ccn_pkg::ccn_req_t                     req,
  input  wire logic [ccn_pkg::NCTR-1:0][ccn_pkg::EVN_W-1:0] ev_num,
  output var ccn_pkg::ccn_rsp_t                      rsp,
  output logic [31:0]                                feature_result_word,
  output logic [ccn_pkg::NCTR-1:0][7:0]              ev_code,
  output logic [ccn_pkg::NCTR-1:0][7:0]              ev_umask,
  output logic [ccn_pkg::NCTR-1:0]                   monitor_pins,
  output logic                                       perf_irq
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // qualified condition of one source under one setup word
  function automatic logic ccn_cond(
    input logic [ccn_pkg::SETUP_W-1:0] s,
    input logic [ccn_pkg::EVN_W-1:0]   n
  );
    logic [7:0] cm;
    logic       r;
    cm = s[ccn_pkg::CMASK_MSB:ccn_pkg::CMASK_LSB];
    if (cm != 8'h00) begin
      r = ({4'h0, n} >= cm) ^ s[ccn_pkg::INV_BIT];
    end else begin
      r = (n != 4'h0);
    end
    return r;
  endfunction

  // amount added in one cycle
  function automatic logic [ccn_pkg::EVN_W-1:0] ccn_inc(
    input logic [ccn_pkg::SETUP_W-1:0] s,
    input logic [ccn_pkg::EVN_W-1:0]   n,
    input logic                        cond,
    input logic                        prev
  );
    logic [ccn_pkg::EVN_W-1:0] r;
    if (s[ccn_pkg::EDGE_BIT]) begin
      r = {3'h0, cond & ~prev};
    end else if (s[ccn_pkg::CMASK_MSB:ccn_pkg::CMASK_LSB] != 8'h00) begin
      r = {3'h0, cond};
    end else begin
      r = n;
    end
    return r;
  endfunction

  // counter write: low word kept, top byte copies bit 31
  function automatic logic [ccn_pkg::CTR_W-1:0] ccn_sext(
    input logic [ccn_pkg::STAMP_W-1:0] w
  );
    return {{(ccn_pkg::CTR_W - ccn_pkg::WR_LOW_W){w[ccn_pkg::SIGN_BIT]}},
            w[ccn_pkg::WR_LOW_W-1:0]};
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  ccn_pkg::ccn_state_t                     st_q;
  ccn_pkg::ccn_state_t                     st_d;
  logic                                    priv0;
  logic                                    rd_ok;
  logic [ccn_pkg::NCTR-1:0]                lvl_ok;
  logic [ccn_pkg::NCTR-1:0]                active;
  logic [ccn_pkg::NCTR-1:0]                cond;
  logic [ccn_pkg::NCTR-1:0][ccn_pkg::EVN_W-1:0] inc;
  logic [ccn_pkg::NCTR-1:0][ccn_pkg::CTR_W:0]   sum;
  logic [ccn_pkg::NCTR-1:0]                ovf;
  logic [ccn_pkg::NCTR-1:0]                trig;
  logic [ccn_pkg::STAMP_W-1:0]             rd_data;

  // v86 code never counts as ring 0
  assign priv0 = (cur_priv == ccn_pkg::CPL_RING0) && !v86_mode;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    st_d    = st_q;
    rd_ok   = 1'b1;
    rd_data = '0;
    // free-running: no halt or stop-clock input gates it
    st_d.stamp = st_q.stamp + 64'h1;
    st_d.rsp   = '0;
    st_d.irq   = 1'b0;
    st_d.feat  = ccn_pkg::FEAT_WORD;

    // counting, one lane per counter
    for (int i = 0; i < ccn_pkg::NCTR; i++) begin
      lvl_ok[i] = priv0 ? st_q.setup[i][ccn_pkg::OS_BIT]
                        : st_q.setup[i][ccn_pkg::USR_BIT];
      // shared enable lives only in setup 0
      active[i] = st_q.setup[0][ccn_pkg::EN_BIT] & lvl_ok[i];
      cond[i]   = ccn_cond(st_q.setup[i], ev_num[i]) & active[i];
      inc[i]    = active[i] ? ccn_inc(st_q.setup[i], ev_num[i], cond[i],
                                      st_q.prev_cond[i]) : '0;
      sum[i]    = {1'b0, st_q.count[i]} + {37'h0, inc[i]};
      ovf[i]    = sum[i][ccn_pkg::CTR_W];
      st_d.count[i]     = sum[i][ccn_pkg::CTR_W-1:0];
      st_d.prev_cond[i] = cond[i];
      trig[i] = st_q.setup[i][ccn_pkg::PC_BIT] ? ovf[i]
                                              : (inc[i] != '0);
      if (ovf[i] && st_q.setup[i][ccn_pkg::INT_BIT]) begin
        st_d.irq = 1'b1;
      end

      // pin pulse; a trigger during a pulse is absorbed by it
      case (st_q.pin_st[i])
        ccn_pkg::PIN_IDLE: begin
          if (trig[i]) begin
            st_d.pin_st[i] = ccn_pkg::PIN_HIGH;
            st_d.hold[i]   = ccn_pkg::PIN_HOLD_LOAD;
            st_d.pins[i]   = 1'b1;
          end
        end
        ccn_pkg::PIN_HIGH: begin
          if (st_q.hold[i] == '0) begin
            st_d.pin_st[i] = ccn_pkg::PIN_IDLE;
            st_d.pins[i]   = 1'b0;
          end else begin
            st_d.hold[i] = st_q.hold[i] - 4'h1;
          end
        end
        default: begin
          st_d.pin_st[i] = ccn_pkg::PIN_IDLE;
          st_d.pins[i]   = 1'b0;
        end
      endcase
    end

    // requests: one answer the next cycle, no ordering wait
    if (req.valid) begin
      st_d.rsp.valid = 1'b1;
      case (req.op)
        ccn_pkg::OP_STAMP_RD: begin
          rd_ok   = priv0 || !control_reg_four[ccn_pkg::TSD_BIT];
          rd_data = st_q.stamp;
        end
        ccn_pkg::OP_COUNT_RD: begin
          rd_ok = priv0 || !control_reg_four[ccn_pkg::PCE_BIT];
          case (req.sel)
            ccn_pkg::SEL_COUNT0: rd_data = {24'h0, st_q.count[0]};
            ccn_pkg::SEL_COUNT1: rd_data = {24'h0, st_q.count[1]};
            default:             rd_ok   = 1'b0;
          endcase
        end
        ccn_pkg::OP_MODEL_RD: begin
          rd_ok = priv0;
          case (req.sel)
            ccn_pkg::SEL_STAMP:  rd_data = st_q.stamp;
            ccn_pkg::SEL_SETUP0: rd_data = {32'h0, st_q.setup[0]};
            ccn_pkg::SEL_SETUP1: rd_data = {32'h0, st_q.setup[1]};
            ccn_pkg::SEL_COUNT0: rd_data = {24'h0, st_q.count[0]};
            ccn_pkg::SEL_COUNT1: rd_data = {24'h0, st_q.count[1]};
            default:             rd_ok   = 1'b0;
          endcase
        end
        ccn_pkg::OP_MODEL_WR: begin
          rd_ok = priv0;
          // a write takes over any increment of the same cycle
          if (priv0) begin
            case (req.sel)
              ccn_pkg::SEL_STAMP:
                st_d.stamp = {32'h0, req.wdata[31:0]};
              ccn_pkg::SEL_SETUP0:
                st_d.setup[0] = req.wdata[31:0];
              ccn_pkg::SEL_SETUP1:
                st_d.setup[1] = req.wdata[31:0];
              ccn_pkg::SEL_COUNT0:
                st_d.count[0] = ccn_sext(req.wdata);
              ccn_pkg::SEL_COUNT1:
                st_d.count[1] = ccn_sext(req.wdata);
              default:
                rd_ok = 1'b0;
            endcase
          end
        end
        default: rd_ok = 1'b0;
      endcase
      st_d.rsp.fault = !rd_ok;
      st_d.rsp.data  = (rd_ok && req.op != ccn_pkg::OP_MODEL_WR) ? rd_data
                                                                  : '0;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q        <= '0;
      st_q.feat   <= ccn_pkg::FEAT_WORD;
      st_q.pin_st <= '{ccn_pkg::PIN_IDLE, ccn_pkg::PIN_IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign rsp                 = st_q.rsp;
  assign feature_result_word = st_q.feat;
  assign monitor_pins        = st_q.pins;
  assign perf_irq            = st_q.irq;
  always_comb begin
    for (int i = 0; i < ccn_pkg::NCTR; i++) begin
      ev_code[i]  = st_q.setup[i][ccn_pkg::EVSEL_MSB:ccn_pkg::EVSEL_LSB];
      ev_umask[i] = st_q.setup[i][ccn_pkg::UMASK_MSB:ccn_pkg::UMASK_LSB];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic wr_acc;
  assign wr_acc = req.valid && req.op == ccn_pkg::OP_MODEL_WR && priv0;

  chk_stamp_counts: assert property (
    !(wr_acc && req.sel == ccn_pkg::SEL_STAMP)
      |=> st_q.stamp == $past(st_q.stamp) + 64'h1)
    else $error("stamp counter did not advance");

  chk_stamp_reset: assert property (disable iff (1'b0)
    sys_rst |=> st_q.stamp == 64'h0)
    else $error("stamp counter not cleared by reset");

  chk_stamp_write: assert property (
    wr_acc && req.sel == ccn_pkg::SEL_STAMP
      |=> st_q.stamp == {32'h0, $past(req.wdata[31:0])})
    else $error("stamp write not zero extended");

  chk_stamp_gate: assert property (
    req.valid && req.op == ccn_pkg::OP_STAMP_RD && !priv0
      && control_reg_four[ccn_pkg::TSD_BIT] |=> rsp.valid && rsp.fault)
    else $error("restricted stamp read not refused");

  chk_count_gate: assert property (
    req.valid && req.op == ccn_pkg::OP_COUNT_RD && !priv0
      && control_reg_four[ccn_pkg::PCE_BIT] |=> rsp.fault)
    else $error("restricted counter read not refused");

  chk_model_priv: assert property (
    req.valid && (req.op == ccn_pkg::OP_MODEL_RD
      || req.op == ccn_pkg::OP_MODEL_WR) && !priv0 |=> rsp.fault)
    else $error("model access outside ring 0 accepted");

  chk_count_sext: assert property (
    wr_acc && req.sel == ccn_pkg::SEL_COUNT0
      |=> st_q.count[0] == {{8{$past(req.wdata[31])}},
                            $past(req.wdata[31:0])})
    else $error("counter write not sign extended");

  chk_pin_width: assert property (
    $rose(monitor_pins[0]) |-> monitor_pins[0] [*8] ##1 !monitor_pins[0])
    else $error("monitor pin pulse has wrong length");

  chk_irq_cause: assert property (
    perf_irq |-> $past((ovf[0] && st_q.setup[0][ccn_pkg::INT_BIT])
      || (ovf[1] && st_q.setup[1][ccn_pkg::INT_BIT])))
    else $error("interrupt without enabled overflow");

  chk_stop_all: assert property (
    !st_q.setup[0][ccn_pkg::EN_BIT] && !wr_acc
      |=> st_q.count == $past(st_q.count))
    else $error("counter moved while disabled");

  chk_feature_bit: assert property (
    feature_result_word[ccn_pkg::FEAT_TSC_BIT])
    else $error("stamp feature bit missing");

  // every request gets its answer on the very next edge
  chk_rsp_answer: assert property (
    req.valid |=> rsp.valid)
    else $error("request not answered");

  // no answer appears without a request
  chk_rsp_quiet: assert property (
    !req.valid |=> !rsp.valid)
    else $error("answer without request");

  // an accepted write answers clean with zero data
  chk_write_nodata: assert property (
    wr_acc |=> !rsp.fault && rsp.data == 64'h0)
    else $error("write answer carries data or fault");

  // an all-zero second setup freezes the second counter
  chk_count1_stop: assert property (
    st_q.setup[1] == 32'h0 && !(wr_acc && req.sel == ccn_pkg::SEL_COUNT1)
      |=> st_q.count[1] == $past(st_q.count[1]))
    else $error("second counter moved with zero setup");

  // a wrap with interrupt enabled raises the line next edge
  chk_wrap_irq: assert property (
    ovf[0] && st_q.setup[0][ccn_pkg::INT_BIT] |=> perf_irq)
    else $error("overflow interrupt missing");

  // a trigger on an idle pin starts the pulse
  chk_pin_event: assert property (
    trig[0] && st_q.pin_st[0] == ccn_pkg::PIN_IDLE |=> monitor_pins[0])
    else $error("monitor pin did not start");

  // pin-on-overflow keeps the pin quiet on plain events
  chk_pin_quiet: assert property (
    st_q.setup[0][ccn_pkg::PC_BIT] && !ovf[0]
      && st_q.pin_st[0] == ccn_pkg::PIN_IDLE |=> !monitor_pins[0])
    else $error("monitor pin toggled without overflow");

  // edge mode adds at most one per cycle
  chk_edge_step: assert property (
    active[0] && st_q.setup[0][ccn_pkg::EDGE_BIT]
      && !(wr_acc && req.sel == ccn_pkg::SEL_COUNT0)
      |=> st_q.count[0] == $past(st_q.count[0])
       || st_q.count[0] == $past(st_q.count[0]) + 40'h1)
    else $error("edge mode added more than one");

  // threshold mode adds at most one per cycle
  chk_thresh_step: assert property (
    active[0] && st_q.setup[0][ccn_pkg::CMASK_MSB:ccn_pkg::CMASK_LSB] != 8'h0
      && !(wr_acc && req.sel == ccn_pkg::SEL_COUNT0)
      |=> st_q.count[0] == $past(st_q.count[0])
       || st_q.count[0] == $past(st_q.count[0]) + 40'h1)
    else $error("threshold mode added more than one");

  // zero threshold adds the whole per-cycle event number
  chk_sum_add: assert property (
    active[0] && !st_q.setup[0][ccn_pkg::EDGE_BIT]
      && st_q.setup[0][ccn_pkg::CMASK_MSB:ccn_pkg::CMASK_LSB] == 8'h0
      && !(wr_acc && req.sel == ccn_pkg::SEL_COUNT0)
      |=> st_q.count[0] == $past(st_q.count[0]) + {36'h0, $past(ev_num[0])})
    else $error("event number not added");

  // a level filter that blocks the counter freezes it
  chk_level_gate: assert property (
    !active[0] && !(wr_acc && req.sel == ccn_pkg::SEL_COUNT0)
      |=> st_q.count[0] == $past(st_q.count[0]))
    else $error("counter moved outside its levels");

  cov_edge_count: cover property (
    active[0] && st_q.setup[0][ccn_pkg::EDGE_BIT] && inc[0] != 4'h0);
  cov_stamp_write: cover property (wr_acc && req.sel == ccn_pkg::SEL_STAMP);
  cov_overflow_irq: cover property (perf_irq);
  cov_pin_pulse: cover property ($fell(monitor_pins[1]));
  cov_ring3_read: cover property (
    req.valid && req.op == ccn_pkg::OP_COUNT_RD && !priv0
    ##1 rsp.valid && !rsp.fault);

endmodule // ccn_top

`default_nettype wire

// >>> tb/ccn_core_model.sv
// ccn_core_model.sv - core event source model feeding the counter unit
`timescale 1ns/1ps
`default_nettype none

module ccn_core_model (
  input  wire logic            clk,
  input  wire logic            go,
  input  wire logic [7:0]      len,
  input  wire logic [1:0][3:0] vals,
  output logic      [1:0][3:0] ev_num
);
  // ************************************************************
  // burst of events
  // ************************************************************
  logic [7:0] left_q = 8'h00;

  // a burst lasts len cycles; the sources report no events outside it
  always_ff @(posedge clk) begin
    if (go) begin
      left_q <= len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  // idle cycles report zero, which is a real count, not a released line
  assign ev_num = (left_q != 8'h00) ? vals : '0;
endmodule // ccn_core_model

`default_nettype wire

// >>> tb/ccn_top_bench.sv
// ccn_top_bench.sv - self-checking bench for the counter unit
`timescale 1ns/1ps
`default_nettype none

module ccn_top_bench;
  // ************************************************************
  // signals
  // ************************************************************
  localparam logic [31:0] EN = 32'h0040_0000, OS = 32'h0002_0000;
  localparam logic [31:0] USER_LEVEL_COUNT = 32'h0001_0000, EDG = 32'h0004_0000;
  localparam logic [31:0] PC = 32'h0008_0000, INTE = 32'h0010_0000;
  localparam logic [31:0] FLIP_THRESHOLD_COMPARE = 32'h0080_0000;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [1:0]        cur_priv = 2'h0;
  logic              v86_mode = 1'b0;
  logic [31:0]       control_reg_four = 32'h0;
  ccn_pkg::ccn_req_t req = '0;
  ccn_pkg::ccn_rsp_t rsp;
  logic [1:0][3:0]   ev_num;
  logic [31:0]       feature_result_word;
  logic [1:0][7:0]   ev_code;
  logic [1:0][7:0]   ev_umask;
  logic [1:0]        monitor_pins;
  logic              perf_irq;
  logic              go = 1'b0;
  logic [7:0]        len = 8'h00;
  logic [1:0][3:0]   vals = '0;
  logic [63:0]       rd;
  logic              flt;
  int                err_count = 0;
  int                total_checks = 0;

  ccn_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .cur_priv(cur_priv),
    .v86_mode(v86_mode), .control_reg_four(control_reg_four),
    .req(req), .ev_num(ev_num), .rsp(rsp),
    .feature_result_word(feature_result_word), .ev_code(ev_code),
    .ev_umask(ev_umask), .monitor_pins(monitor_pins), .perf_irq(perf_irq)
  );

  ccn_core_model i_core (
    .clk(clk), .go(go), .len(len), .vals(vals), .ev_num(ev_num)
  );

  // 4 ns clock
  initial begin
    forever #2 clk = ~clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // request held for its taking edge; answer looked at 1 ns after that edge
  task automatic xfer(ccn_pkg::ccn_op_t op, ccn_pkg::ccn_sel_t sel,
                      logic [63:0] w);
    @(posedge clk);
    req <= '{1'b1, op, sel, w};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk(64'(rsp.valid), 64'h1);
    rd = rsp.data;
    flt = rsp.fault;
  endtask

  task automatic wr(ccn_pkg::ccn_sel_t sel, logic [63:0] w);
    xfer(ccn_pkg::OP_MODEL_WR, sel, w);
  endtask

  task automatic fire(logic [1:0][3:0] v, logic [7:0] n);
    @(posedge clk);
    go <= 1'b1;
    len <= n;
    vals <= v;
    @(posedge clk);
    go <= 1'b0;
  endtask

  // every call sets all three levels, so none is assigned twice at once
  task automatic pr(ccn_pkg::ccn_op_t op, ccn_pkg::ccn_sel_t sel,
                    logic [1:0] p, logic v, logic [31:0] cr, logic e);
    cur_priv <= p;
    v86_mode <= v;
    control_reg_four <= cr;
    xfer(op, sel, 64'h0);
    chk(64'(flt), 64'(e));
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_stamp();
    logic [63:0] a;
    xfer(ccn_pkg::OP_STAMP_RD, ccn_pkg::SEL_STAMP, 64'h0);
    a = rd;
    chk(64'(feature_result_word), 64'h10);
    chk(64'(a < 64'h20), 64'h1);
    xfer(ccn_pkg::OP_STAMP_RD, ccn_pkg::SEL_STAMP, 64'h0);
    chk(rd - a, 64'h2);
    wr(ccn_pkg::SEL_STAMP, 64'hdead_beef_1234_5678);
    xfer(ccn_pkg::OP_MODEL_RD, ccn_pkg::SEL_STAMP, 64'h0);
    chk({32'h0, rd[63:32]}, 64'h0);
    chk(64'(rd[31:0] - 32'h1234_5678 < 32'h4), 64'h1);
  endtask

  task automatic t_priv();
    pr(ccn_pkg::OP_STAMP_RD, ccn_pkg::SEL_STAMP, 2'h3, 1'b0, 32'h4, 1);
    pr(ccn_pkg::OP_STAMP_RD, ccn_pkg::SEL_STAMP, 2'h0, 1'b0, 32'h4, 0);
    pr(ccn_pkg::OP_STAMP_RD, ccn_pkg::SEL_STAMP, 2'h0, 1'b1, 32'h4, 1);
    pr(ccn_pkg::OP_STAMP_RD, ccn_pkg::SEL_STAMP, 2'h3, 1'b1, 32'h0, 0);
    pr(ccn_pkg::OP_COUNT_RD, ccn_pkg::SEL_COUNT0, 2'h3, 1'b0, 32'h100, 1);
    pr(ccn_pkg::OP_COUNT_RD, ccn_pkg::SEL_COUNT1, 2'h2, 1'b0, 32'h0, 0);
    pr(ccn_pkg::OP_MODEL_RD, ccn_pkg::SEL_SETUP0, 2'h1, 1'b0, 32'h0, 1);
    pr(ccn_pkg::OP_MODEL_RD, ccn_pkg::SEL_SETUP0, 2'h0, 1'b0, 32'h0, 0);
  endtask

  task automatic t_regs();
    wr(ccn_pkg::SEL_COUNT0, 64'h0000_0000_8000_0001);
    xfer(ccn_pkg::OP_MODEL_RD, ccn_pkg::SEL_COUNT0, 64'h0);
    chk(rd, 64'h0000_00ff_8000_0001);
    wr(ccn_pkg::SEL_COUNT1, 64'hffff_ffff_7fff_fffe);
    pr(ccn_pkg::OP_MODEL_WR, ccn_pkg::SEL_COUNT1, 2'h3, 1'b0, 32'h0, 1);
    pr(ccn_pkg::OP_MODEL_RD, ccn_pkg::SEL_COUNT1, 2'h0, 1'b0, 32'h0, 0);
    chk(rd, 64'h0000_0000_7fff_fffe);
    wr(ccn_pkg::SEL_SETUP1, 64'hffff_ffff_2183_1234);
    xfer(ccn_pkg::OP_MODEL_RD, ccn_pkg::SEL_SETUP1, 64'h0);
    chk(rd, 64'h2183_1234);
    chk({ev_umask[1], ev_code[1]}, 64'h1234);
  endtask

  // counts of counter 0 (3 events a cycle) and 1 (1 a cycle), 5 cycles
  task automatic run(logic [31:0] s0, logic [31:0] s1, logic [1:0] p,
                     logic [63:0] e0, logic [63:0] e1);
    wr(ccn_pkg::SEL_SETUP1, {32'h0, s1});
    wr(ccn_pkg::SEL_SETUP0, {32'h0, s0});
    wr(ccn_pkg::SEL_COUNT0, 64'h0);
    wr(ccn_pkg::SEL_COUNT1, 64'h0);
    cur_priv <= p;
    fire({4'h1, 4'h3}, 8'd5);
    repeat (8) @(posedge clk);
    cur_priv <= 2'h0;
    xfer(ccn_pkg::OP_MODEL_RD, ccn_pkg::SEL_COUNT0, 64'h0);
    chk(rd, e0);
    xfer(ccn_pkg::OP_MODEL_RD, ccn_pkg::SEL_COUNT1, 64'h0);
    chk(rd, e1);
  endtask

  task automatic t_count();
    logic [63:0] a;
    run(EN | OS, OS, 2'h0, 64'd15, 64'd5);
    run(EN | USER_LEVEL_COUNT, OS | USER_LEVEL_COUNT, 2'h0, 64'd0, 64'd5);
    run(EN | USER_LEVEL_COUNT, OS, 2'h3, 64'd15, 64'd0);
    run(EN | OS | 32'h0200_0000, OS | 32'h0100_0000, 2'h0, 5, 5);
    run(EN | OS | EDG, OS | EDG, 2'h0, 64'd1, 64'd1);
    run(EN | OS, 32'h0, 2'h0, 64'd15, 64'd0);
    run(OS, OS, 2'h0, 64'd0, 64'd0);
    // inverted compare counts the idle cycles, two between reads
    wr(ccn_pkg::SEL_SETUP1, {32'h0, OS | FLIP_THRESHOLD_COMPARE | 32'h0100_0000});
    wr(ccn_pkg::SEL_SETUP0, {32'h0, EN | OS});
    xfer(ccn_pkg::OP_COUNT_RD, ccn_pkg::SEL_COUNT1, 64'h0);
    a = rd;
    xfer(ccn_pkg::OP_COUNT_RD, ccn_pkg::SEL_COUNT1, 64'h0);
    chk(rd - a, 64'h2);
  endtask

  task automatic t_ovf();
    int np;
    int ni;
    wr(ccn_pkg::SEL_SETUP1, 64'h0);
    wr(ccn_pkg::SEL_SETUP0, {32'h0, EN | OS | PC | INTE});
    wr(ccn_pkg::SEL_COUNT0, 64'hffff_ffff);
    for (int k = 0; k < 2; k++) begin
      np = 0;
      ni = 0;
      fire({4'h0, 4'h1}, 8'd1);
      repeat (20) begin
        @(posedge clk);
        #1;
        np += int'(monitor_pins[0] === 1'b1);
        ni += int'(perf_irq === 1'b1);
      end
      // first event wraps; the second one leaves the pin quiet
      chk(64'(np), (k == 0) ? 64'h8 : 64'h0);
      chk(64'(ni), (k == 0) ? 64'h1 : 64'h0);
    end
    xfer(ccn_pkg::OP_MODEL_RD, ccn_pkg::SEL_COUNT0, 64'h0);
    chk(rd, 64'h1);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_stamp();
    t_priv();
    t_regs();
    t_count();
    t_ovf();
    test_done();
  end

  // the run needs well under 1500 cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule // ccn_top_bench

`default_nettype wire
